// [design/opsr_regs.sv]
`timescale 1ns/1ps
// What this block does
// - Control current-count field reads the live counter; a write loads it.
// - Threshold is seven upper bits 26:20 joined with sixteen lower bits 15:0.
// - Counter bits 26:4 equal to threshold tags the next op.
// - Source bit clear counts core clocks; set counts dispatched ops.
// - Tagged op retiring sets sample valid and stops the counter.
// - A new valid sample raises an interrupt request.
// - Enable bit turns sampling on when set, off when clear.
// - Linear-address register holds the tagged op's instruction address.
// - Address-invalid flag is set when that address is not valid.
// - Branch retired, mispredicted and taken flags at bits 37, 36, 35.
// - Return flag set for a retired subroutine return.
// - An access crossing 128 bits reports only its lower portion.
// - Miss latency counts core cycles from miss detection to data return, zero for a store.
// - Physical and linear operand address valid flags at bits 18 and 17.
// - Locked, uncacheable and write-combining flags at bits 15, 14, 13.
// - Misaligned penalty at bit 8, cache miss at bit 7.
// - Data TLB 1G hit bit 5, 2M hit bit 4, miss bit 2.
// - Store at bit 1, load at bit 0.
// - Counter advances only while enabled and sample valid is clear.
// - Aborted tagged op: no sample, counter 26:7 cleared, 6:0 random.
module opsr_regs
(
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire opsr_pkg::opsr_msr_req_t     msr_req,
  output logic      [63:0]                 msr_rdata,
  output logic                             msr_ack,
  input  wire logic                        op_dispatch,
  input  wire logic                        tagged_retire,
  input  wire logic                        tagged_abort,
  input  wire opsr_pkg::opsr_retire_t      retire_info,
  input  wire logic                        dc_miss_detect,
  input  wire logic                        dc_data_return,
  output logic                             tag_request,
  output logic                             sample_irq
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic [opsr_pkg::CNT_W-1:0]        cnt_q;
  logic [opsr_pkg::CNT_W-1:0]        cnt_d;
  logic [22:0]                       thr_q;
  logic [22:0]                       thr_d;
  logic                              src_q;
  logic                              src_d;
  logic                              val_q;
  logic                              val_d;
  logic                              en_q;
  logic                              en_d;
  logic [63:0]                       rip_q;
  logic [63:0]                       rip_d;
  logic [63:0]                       br_q;
  logic [63:0]                       br_d;
  logic [63:0]                       dc_q;
  logic [63:0]                       dc_d;
  opsr_pkg::opsr_tag_state_t         tag_q;
  opsr_pkg::opsr_tag_state_t         tag_d;
  logic                              irq_q;
  logic                              irq_d;
  logic [63:0]                       rdata_q;
  logic [63:0]                       rdata_d;
  logic                              ack_q;

  logic                              wr;
  logic                              ctl_wr;
  logic                              advance;
  logic                              match;
  logic                              retire_fire;
  logic                              abort_fire;
  logic [opsr_pkg::RAND_W-1:0]       rand_val;
  logic [opsr_pkg::LAT_W-1:0]        lat_count;

  opsr_lfsr u_lfsr
  (
    .clk   (clk),
    .reset (reset),
    .value (rand_val)
  );

  // The timer restarts whenever a new op becomes the tagged one.
  opsr_latency u_latency
  (
    .clk   (clk),
    .reset (reset),
    .clear (tag_q == opsr_pkg::TAG_PENDING),
    .start (dc_miss_detect && tag_q == opsr_pkg::TAG_INFLIGHT),
    .stop  (dc_data_return),
    .count (lat_count)
  );

  // ==========================================================================
  // Decode and events
  // ==========================================================================
  assign wr          = msr_req.valid && msr_req.write;
  assign ctl_wr      = wr && msr_req.index == opsr_pkg::IDX_CONTROL;
  assign advance     = en_q && !val_q && (src_q ? op_dispatch : 1'b1);
  assign match       = cnt_q[26:4] == thr_q;
  assign retire_fire = tagged_retire && tag_q == opsr_pkg::TAG_INFLIGHT;
  assign abort_fire  = tagged_abort && tag_q == opsr_pkg::TAG_INFLIGHT;

  // ==========================================================================
  // Control register and op interval counter
  // ==========================================================================
  always_comb
  begin
    cnt_d = cnt_q;
    thr_d = thr_q;
    src_d = src_q;
    en_d  = en_q;
    val_d = val_q;
    if (ctl_wr)
    begin
      cnt_d = msr_req.wdata[opsr_pkg::CTL_CUR_MSB:opsr_pkg::CTL_CUR_LSB];
      thr_d = {msr_req.wdata[opsr_pkg::CTL_THR_HI_MSB:opsr_pkg::CTL_THR_HI_LSB],
               msr_req.wdata[opsr_pkg::CTL_THR_LO_MSB:opsr_pkg::CTL_THR_LO_LSB]};
      src_d = msr_req.wdata[opsr_pkg::CTL_SRC_BIT];
      en_d  = msr_req.wdata[opsr_pkg::CTL_ENABLE_BIT];
      val_d = msr_req.wdata[opsr_pkg::CTL_VALID_BIT];
    end
    else if (abort_fire)
      cnt_d = {20'h0, rand_val};
    else if (advance)
      cnt_d = opsr_pkg::CNT_W'(cnt_q + 27'h1);
    // A retire in the same cycle as a clearing write must not be lost.
    if (retire_fire)
      val_d = 1'b1;
  end

  // ==========================================================================
  // Tagging sequence
  // ==========================================================================
  always_comb
  begin
    tag_d = tag_q;
    unique case (tag_q)
      opsr_pkg::TAG_IDLE:
        if (en_q && !val_q && match)
          tag_d = opsr_pkg::TAG_PENDING;
      opsr_pkg::TAG_PENDING:
        if (op_dispatch)
          tag_d = opsr_pkg::TAG_INFLIGHT;
      opsr_pkg::TAG_INFLIGHT:
        if (retire_fire || abort_fire)
          tag_d = opsr_pkg::TAG_IDLE;
    endcase
    // Dropping the enable abandons any op still waiting for its tag.
    if (!en_q)
      tag_d = opsr_pkg::TAG_IDLE;
  end

  assign tag_request = tag_q == opsr_pkg::TAG_PENDING;

  // ==========================================================================
  // Sample registers
  // ==========================================================================
  // Hardware capture takes priority over a software write in the same cycle.
  always_comb
  begin
    rip_d = rip_q;
    br_d  = br_q;
    dc_d  = dc_q;
    if (wr && msr_req.index == opsr_pkg::IDX_LIN_ADDR)
      rip_d = msr_req.wdata;
    if (wr && msr_req.index == opsr_pkg::IDX_BRANCH)
      br_d = msr_req.wdata & opsr_pkg::BR_WRITE_MASK;
    if (wr && msr_req.index == opsr_pkg::IDX_DCACHE)
      dc_d = msr_req.wdata & opsr_pkg::DC_WRITE_MASK;
    if (retire_fire)
    begin
      rip_d = retire_info.insn_addr;
      br_d  = '0;
      br_d[opsr_pkg::BR_ADDR_INVALID_BIT] = retire_info.addr_invalid;
      br_d[opsr_pkg::BR_RETIRED_BIT]      = retire_info.br_retired;
      br_d[opsr_pkg::BR_MISPRED_BIT]      = retire_info.br_mispred;
      br_d[opsr_pkg::BR_TAKEN_BIT]        = retire_info.br_taken;
      br_d[opsr_pkg::BR_RETURN_BIT]       = retire_info.sub_return;
      // The core reports only the lower portion of a split access.
      dc_d  = '0;
      dc_d[opsr_pkg::DC_LAT_MSB:opsr_pkg::DC_LAT_LSB] =
        retire_info.is_store ? 16'h0 : lat_count;
      dc_d[opsr_pkg::DC_PHYS_VALID_BIT] = retire_info.phys_valid;
      dc_d[opsr_pkg::DC_LIN_VALID_BIT]  = retire_info.lin_valid;
      dc_d[opsr_pkg::DC_LOCKED_BIT]     = retire_info.locked;
      dc_d[opsr_pkg::DC_UC_BIT]         = retire_info.uncacheable;
      dc_d[opsr_pkg::DC_WC_BIT]         = retire_info.write_comb;
      dc_d[opsr_pkg::DC_MISALIGN_BIT]   = retire_info.misaligned;
      dc_d[opsr_pkg::DC_MISS_BIT]       = retire_info.dc_miss;
      dc_d[opsr_pkg::DC_HIT_1G_BIT]     = retire_info.hit_1g;
      dc_d[opsr_pkg::DC_HIT_2M_BIT]     = retire_info.hit_2m;
      dc_d[opsr_pkg::DC_TLB_MISS_BIT]   = retire_info.tlb_miss;
      dc_d[opsr_pkg::DC_STORE_BIT]      = retire_info.is_store;
      dc_d[opsr_pkg::DC_LOAD_BIT]       = retire_info.is_load;
    end
  end

  // ==========================================================================
  // Read port and interrupt
  // ==========================================================================
  always_comb
  begin
    rdata_d = rdata_q;
    irq_d   = val_d && !val_q;
    if (msr_req.valid && !msr_req.write)
    begin
      rdata_d = '0;
      unique case (msr_req.index)
        opsr_pkg::IDX_CONTROL:
        begin
          rdata_d[opsr_pkg::CTL_CUR_MSB:opsr_pkg::CTL_CUR_LSB]       = cnt_q;
          rdata_d[opsr_pkg::CTL_THR_HI_MSB:opsr_pkg::CTL_THR_HI_LSB] = thr_q[22:16];
          rdata_d[opsr_pkg::CTL_SRC_BIT]                             = src_q;
          rdata_d[opsr_pkg::CTL_VALID_BIT]                           = val_q;
          rdata_d[opsr_pkg::CTL_ENABLE_BIT]                          = en_q;
          rdata_d[opsr_pkg::CTL_THR_LO_MSB:opsr_pkg::CTL_THR_LO_LSB] = thr_q[15:0];
        end
        opsr_pkg::IDX_LIN_ADDR: rdata_d = rip_q;
        opsr_pkg::IDX_BRANCH:   rdata_d = br_q;
        opsr_pkg::IDX_DCACHE:   rdata_d = dc_q;
        default:                rdata_d = '0;
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_q   <= opsr_pkg::CNT_RESET;
      thr_q   <= '0;
      src_q   <= 1'b0;
      val_q   <= 1'b0;
      en_q    <= 1'b0;
      rip_q   <= opsr_pkg::REG_RESET;
      br_q    <= opsr_pkg::REG_RESET;
      dc_q    <= opsr_pkg::REG_RESET;
      tag_q   <= opsr_pkg::TAG_IDLE;
      irq_q   <= 1'b0;
      rdata_q <= opsr_pkg::REG_RESET;
      ack_q   <= 1'b0;
    end
    else
    begin
      cnt_q   <= cnt_d;
      thr_q   <= thr_d;
      src_q   <= src_d;
      val_q   <= val_d;
      en_q    <= en_d;
      rip_q   <= rip_d;
      br_q    <= br_d;
      dc_q    <= dc_d;
      tag_q   <= tag_d;
      irq_q   <= irq_d;
      rdata_q <= rdata_d;
      ack_q   <= msr_req.valid;
    end
  end

  assign msr_rdata  = rdata_q;
  assign msr_ack    = ack_q;
  assign sample_irq = irq_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  cnt_clock_a: assert property (@(posedge clk) disable iff (reset)
    en_q && !val_q && !src_q && !ctl_wr && !abort_fire |=> cnt_q == $past(cnt_q) + 27'h1)
    else $error("counter did not advance on a core clock");

  cnt_hold_a: assert property (@(posedge clk) disable iff (reset)
    (val_q || !en_q) && !ctl_wr && !abort_fire |=> $stable(cnt_q))
    else $error("counter moved while stopped");

  cnt_load_a: assert property (@(posedge clk) disable iff (reset)
    ctl_wr |=> cnt_q == $past(msr_req.wdata[58:32]))
    else $error("counter not loaded by control write");

  tag_match_a: assert property (@(posedge clk) disable iff (reset)
    tag_q == opsr_pkg::TAG_IDLE && en_q && !val_q && match && !ctl_wr |=> tag_request)
    else $error("no tag after threshold match");

  capture_val_a: assert property (@(posedge clk) disable iff (reset)
    retire_fire |=> val_q && rip_q == $past(retire_info.insn_addr))
    else $error("retire did not capture sample");

  irq_raise_a: assert property (@(posedge clk) disable iff (reset)
    $rose(val_q) |-> sample_irq ##1 !sample_irq)
    else $error("interrupt not raised once for new sample");

  abort_reload_a: assert property (@(posedge clk) disable iff (reset)
    abort_fire && !ctl_wr |=> cnt_q[26:7] == 20'h0 && !val_q)
    else $error("abort handling wrong");

  disable_idle_a: assert property (@(posedge clk) disable iff (reset)
    !en_q |=> !tag_request)
    else $error("tagging while disabled");

  branch_flags_a: assert property (@(posedge clk) disable iff (reset)
    retire_fire |=> br_q[37:34] == $past({retire_info.br_retired, retire_info.br_mispred,
                                         retire_info.br_taken, retire_info.sub_return}))
    else $error("branch flags not captured");

endmodule

// [design/opsr_pkg.sv]
package opsr_pkg;

  // ==========================================================================
  // Register indices on the model-specific register port
  // ==========================================================================
  localparam logic [2:0] IDX_CONTROL   = 3'h0;
  localparam logic [2:0] IDX_LIN_ADDR  = 3'h1;
  localparam logic [2:0] IDX_BRANCH    = 3'h2;
  localparam logic [2:0] IDX_NB_DATA   = 3'h3;
  localparam logic [2:0] IDX_DCACHE    = 3'h4;

  // ==========================================================================
  // Control register fields
  // ==========================================================================
  localparam int CTL_CUR_LSB    = 32;
  localparam int CTL_CUR_MSB    = 58;
  localparam int CTL_THR_HI_LSB = 20;
  localparam int CTL_THR_HI_MSB = 26;
  localparam int CTL_SRC_BIT    = 19;
  localparam int CTL_VALID_BIT  = 18;
  localparam int CTL_ENABLE_BIT = 17;
  localparam int CTL_THR_LO_LSB = 0;
  localparam int CTL_THR_LO_MSB = 15;

  // ==========================================================================
  // Branch data register fields
  // ==========================================================================
  localparam int BR_ADDR_INVALID_BIT = 38;
  localparam int BR_RETIRED_BIT      = 37;
  localparam int BR_MISPRED_BIT      = 36;
  localparam int BR_TAKEN_BIT        = 35;
  localparam int BR_RETURN_BIT       = 34;
  localparam logic [63:0] BR_WRITE_MASK = 64'h0000_007c_0000_0000;

  // ==========================================================================
  // Data-cache register fields
  // ==========================================================================
  localparam int DC_LAT_LSB        = 32;
  localparam int DC_LAT_MSB        = 47;
  localparam int DC_PHYS_VALID_BIT = 18;
  localparam int DC_LIN_VALID_BIT  = 17;
  localparam int DC_LOCKED_BIT     = 15;
  localparam int DC_UC_BIT         = 14;
  localparam int DC_WC_BIT         = 13;
  localparam int DC_MISALIGN_BIT   = 8;
  localparam int DC_MISS_BIT       = 7;
  localparam int DC_HIT_1G_BIT     = 5;
  localparam int DC_HIT_2M_BIT     = 4;
  localparam int DC_TLB_MISS_BIT   = 2;
  localparam int DC_STORE_BIT      = 1;
  localparam int DC_LOAD_BIT       = 0;
  localparam logic [63:0] DC_WRITE_MASK = 64'h0000_ffff_0006_e1b7;

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int CNT_W   = 27;
  localparam int LAT_W   = 16;
  localparam int RAND_W  = 7;
  localparam logic [RAND_W-1:0] LFSR_SEED  = 7'h5a;
  localparam logic [63:0]       REG_RESET  = 64'h0;
  localparam logic [CNT_W-1:0]  CNT_RESET  = 27'h0;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [2:0]  index;
    logic [63:0] wdata;
  } opsr_msr_req_t;

  typedef struct packed {
    logic [63:0] insn_addr;
    logic        addr_invalid;
    logic        br_retired;
    logic        br_mispred;
    logic        br_taken;
    logic        sub_return;
    logic        phys_valid;
    logic        lin_valid;
    logic        locked;
    logic        uncacheable;
    logic        write_comb;
    logic        misaligned;
    logic        dc_miss;
    logic        hit_1g;
    logic        hit_2m;
    logic        tlb_miss;
    logic        is_store;
    logic        is_load;
  } opsr_retire_t;

  typedef enum logic [1:0] {TAG_IDLE, TAG_PENDING, TAG_INFLIGHT} opsr_tag_state_t;

endpackage

// [design/opsr_lfsr.sv]
`timescale 1ns/1ps
module opsr_lfsr
(
  input  wire logic                            clk,
  input  wire logic                            reset,
  output logic      [opsr_pkg::RAND_W-1:0]     value
);

  logic [opsr_pkg::RAND_W-1:0] lfsr_q;
  logic [opsr_pkg::RAND_W-1:0] lfsr_d;

  // ==========================================================================
  // Free-running generator
  // ==========================================================================
  // Maximal-length taps, so the all-zero lockup state is never entered.
  always_comb
  begin
    lfsr_d = {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      lfsr_q <= opsr_pkg::LFSR_SEED;
    else
      lfsr_q <= lfsr_d;
  end

  assign value = lfsr_q;

endmodule

// [design/opsr_latency.sv]
`timescale 1ns/1ps
module opsr_latency
(
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic                          clear,
  input  wire logic                          start,
  input  wire logic                          stop,
  output logic      [opsr_pkg::LAT_W-1:0]    count
);

  logic                         run_q;
  logic                         run_d;
  logic [opsr_pkg::LAT_W-1:0]   cnt_q;
  logic [opsr_pkg::LAT_W-1:0]   cnt_d;

  // ==========================================================================
  // Miss latency timer
  // ==========================================================================
  // The count saturates so a very long miss reads as the largest value.
  always_comb
  begin
    run_d = run_q;
    cnt_d = cnt_q;
    if (clear)
    begin
      run_d = 1'b0;
      cnt_d = '0;
    end
    else if (stop)
    begin
      // The delivery cycle itself still belongs to the miss.
      run_d = 1'b0;
      if (run_q && cnt_q != '1)
        cnt_d = opsr_pkg::LAT_W'(cnt_q + 16'h1);
    end
    else if (start)
    begin
      run_d = 1'b1;
      cnt_d = '0;
    end
    else if (run_q && cnt_q != '1)
      cnt_d = opsr_pkg::LAT_W'(cnt_q + 16'h1);
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      run_q <= 1'b0;
      cnt_q <= '0;
    end
    else
    begin
      run_q <= run_d;
      cnt_q <= cnt_d;
    end
  end

  assign count = cnt_q;

  lat_step_a: assert property (@(posedge clk) disable iff (reset)
    run_q && !clear && !stop && !start && cnt_q != '1 |=> cnt_q == $past(cnt_q) + 16'h1)
    else $error("miss latency did not advance by one");

endmodule

// [sim/opsr_core_model.sv]
`timescale 1ns/1ps
// ============================================================================
// Core pipeline model: dispatches the tagged op, then misses, retires or aborts
// ============================================================================
module opsr_core_model
(
  input  wire logic                   clk,
  input  wire logic                   tag_request,
  input  wire logic                   free_dispatch,
  input  wire logic                   do_abort,
  input  wire logic [7:0]             miss_delay,
  input  wire opsr_pkg::opsr_retire_t info,
  output logic                        op_dispatch,
  output logic                        tagged_retire,
  output logic                        tagged_abort,
  output opsr_pkg::opsr_retire_t      retire_info,
  output logic                        dc_miss_detect,
  output logic                        dc_data_return
);
  // Capture data is only meaningful with the retire pulse, so it shows the inverse outside the retire and abort pulses.
  initial
  begin
    {op_dispatch, tagged_retire, tagged_abort, dc_miss_detect, dc_data_return} = 5'h0;
    retire_info = ~info;
    forever
    begin
      @(negedge clk);
      op_dispatch <= free_dispatch | tag_request;
      if (tag_request === 1'b1)
      begin
        @(negedge clk);
        op_dispatch <= free_dispatch;
        if (info.dc_miss)
        begin
          dc_miss_detect <= 1'b1;
          @(negedge clk);
          dc_miss_detect <= 1'b0;
          repeat (miss_delay - 8'h1) @(negedge clk);
          dc_data_return <= 1'b1;
          @(negedge clk);
          dc_data_return <= 1'b0;
        end
        retire_info   <= info;
        tagged_retire <= !do_abort;
        tagged_abort  <= do_abort;
        @(negedge clk);
        {tagged_retire, tagged_abort} <= 2'h0;
        retire_info <= ~info;
      end
    end
  end
endmodule

// [sim/op_execution_sampling_regs_tb.sv]
`timescale 1ns/1ps
// ============================================================================
// Testbench
// ============================================================================
module op_execution_sampling_regs_tb;
  logic                   clk, reset, msr_ack, op_dispatch, tagged_retire, tagged_abort;
  logic                   dc_miss_detect, dc_data_return, tag_request, sample_irq, free_dispatch, do_abort;
  logic [7:0]             miss_delay;
  logic [63:0]            msr_rdata, rd, rd2;
  opsr_pkg::opsr_msr_req_t msr_req;
  opsr_pkg::opsr_retire_t  retire_info, info;
  int                     mismatches, total_checks, irq_count, n, c0;
  localparam opsr_pkg::opsr_retire_t INFO_A = {64'h0000_7fff_1234_5678, 17'b01101_101011110001};
  localparam opsr_pkg::opsr_retire_t INFO_B = {64'hffff_8000_0000_0040, 17'b10010_010100001110};

  opsr_regs uut (.clk(clk), .reset(reset), .msr_req(msr_req), .msr_rdata(msr_rdata), .msr_ack(msr_ack),
    .op_dispatch(op_dispatch), .tagged_retire(tagged_retire), .tagged_abort(tagged_abort),
    .retire_info(retire_info), .dc_miss_detect(dc_miss_detect), .dc_data_return(dc_data_return),
    .tag_request(tag_request), .sample_irq(sample_irq));
  opsr_core_model core (.clk(clk), .tag_request(tag_request), .free_dispatch(free_dispatch),
    .do_abort(do_abort), .miss_delay(miss_delay), .info(info), .op_dispatch(op_dispatch),
    .tagged_retire(tagged_retire), .tagged_abort(tagged_abort), .retire_info(retire_info),
    .dc_miss_detect(dc_miss_detect), .dc_data_return(dc_data_return));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (sample_irq === 1'b1) irq_count++;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [63:0] ctl_word(input logic [26:0] cur, input logic [22:0] thr, input logic src,
                                           input logic en);
    return {5'h0, cur, 5'h0, thr[22:16], src, 1'b0, en, 1'b0, thr[15:0]};
  endfunction
  function automatic logic [63:0] exp_br(input opsr_pkg::opsr_retire_t i);
    return {25'h0, i.addr_invalid, i.br_retired, i.br_mispred, i.br_taken, i.sub_return, 34'h0};
  endfunction
  function automatic logic [63:0] exp_dc(input opsr_pkg::opsr_retire_t i);
    return {45'h0, i.phys_valid, i.lin_valid, 1'b0, i.locked, i.uncacheable, i.write_comb, 4'h0,
            i.misaligned, i.dc_miss, 1'b0, i.hit_1g, i.hit_2m, 1'b0, i.tlb_miss, i.is_store, i.is_load};
  endfunction
  task automatic stop_test;
    if (mismatches == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp64(input logic [63:0] got, input logic [63:0] exp, input string msg);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask
  // A request is a one-cycle pulse; the answer is looked at while the ack stands.
  task automatic msr(input logic wr, input logic [2:0] idx, input logic [63:0] wd);
    @(negedge clk);
    msr_req <= '{valid: 1'b1, write: wr, index: idx, wdata: wd};
    @(negedge clk);
    msr_req.valid <= 1'b0;
    cmp_flag(msr_ack === 1'b1, "missing ack");
    rd = msr_rdata;
  endtask
  task automatic wait_on(input bit irq, input int bound);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
      if (n > bound)
      begin
        mismatches++;
        $display("CHECK FAILED t=%0t wait expired", $time);
        stop_test();
      end
    end while ((irq ? sample_irq : tag_request) !== 1'b1);
  endtask
  task automatic check_capture(input opsr_pkg::opsr_retire_t i, input logic [15:0] lo, input logic [15:0] hi);
    msr(1'b0, opsr_pkg::IDX_LIN_ADDR, 64'h0);
    cmp64(rd, i.insn_addr, "linear address");
    msr(1'b0, opsr_pkg::IDX_BRANCH, 64'h0);
    cmp64(rd, exp_br(i), "branch data");
    msr(1'b0, opsr_pkg::IDX_DCACHE, 64'h0);
    cmp64(rd & 64'hffff_0000_ffff_ffff, exp_dc(i), "dcache data");
    cmp_flag(rd[47:32] >= lo && rd[47:32] <= hi, "miss latency");
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_regs;
    msr(1'b0, opsr_pkg::IDX_CONTROL, 64'h0);
    cmp64(rd, 64'h0, "control after reset");
    cmp_flag(tag_request === 1'b0 && sample_irq === 1'b0, "idle after reset");
    msr(1'b1, opsr_pkg::IDX_CONTROL, 64'hffff_ffff_fff9_ffff);
    msr(1'b1, 3'h5, 64'h0);
    repeat (6) @(negedge clk);
    msr(1'b0, opsr_pkg::IDX_CONTROL, 64'h0);
    cmp64(rd, 64'h07ff_ffff_07f8_ffff, "control image");
    cmp_flag(tag_request === 1'b0, "tag while disabled");
    msr(1'b0, 3'h5, 64'h0);
    cmp64(rd, 64'h0, "unmapped read");
    msr(1'b0, opsr_pkg::IDX_NB_DATA, 64'h0);
    cmp64(rd, 64'h0, "northbridge read");
    msr(1'b1, opsr_pkg::IDX_LIN_ADDR, 64'hffff_8000_0000_1000);
    msr(1'b0, opsr_pkg::IDX_LIN_ADDR, 64'h0);
    cmp64(rd, 64'hffff_8000_0000_1000, "address write");
    msr(1'b1, opsr_pkg::IDX_BRANCH, 64'hffff_ffff_ffff_ffff);
    msr(1'b0, opsr_pkg::IDX_BRANCH, 64'h0);
    cmp64(rd, opsr_pkg::BR_WRITE_MASK, "branch write");
    msr(1'b1, opsr_pkg::IDX_DCACHE, 64'hffff_ffff_ffff_ffff);
    msr(1'b0, opsr_pkg::IDX_DCACHE, 64'h0);
    cmp64(rd, opsr_pkg::DC_WRITE_MASK, "dcache write");
  endtask
  task automatic t_clock_sample;
    info <= INFO_A;
    msr(1'b1, opsr_pkg::IDX_CONTROL, ctl_word(27'h0, 23'h2, 1'b0, 1'b1));
    wait_on(1'b0, 60);
    cmp_flag(n >= 29 && n <= 35, "clock count to tag");
    c0 = irq_count;
    wait_on(1'b1, 60);
    msr(1'b0, opsr_pkg::IDX_CONTROL, 64'h0);
    cmp_flag(rd[18] === 1'b1 && irq_count == c0 + 1, "valid and one irq");
    repeat (5) @(negedge clk);
    msr(1'b0, opsr_pkg::IDX_CONTROL, 64'h0);
    rd2 = rd;
    msr(1'b0, opsr_pkg::IDX_CONTROL, 64'h0);
    cmp64(rd, rd2, "counter stopped");
    check_capture(INFO_A, 16'h5, 16'h5);
  endtask
  task automatic t_dispatch_sample;
    info <= INFO_B;
    msr(1'b1, opsr_pkg::IDX_CONTROL, ctl_word(27'h0, 23'h1, 1'b1, 1'b1));
    repeat (20) @(negedge clk);
    msr(1'b0, opsr_pkg::IDX_CONTROL, 64'h0);
    cmp64({37'h0, rd[58:32]}, 64'h0, "no count without ops");
    free_dispatch <= 1'b1;
    wait_on(1'b1, 80);
    free_dispatch <= 1'b0;
    check_capture(INFO_B, 16'h0, 16'h0);
  endtask
  task automatic t_abort;
    info <= INFO_A;
    do_abort <= 1'b1;
    c0 = irq_count;
    msr(1'b1, opsr_pkg::IDX_CONTROL, ctl_word(27'h0, 23'h1, 1'b0, 1'b1));
    n = 0;
    while (tagged_abort !== 1'b1 && n < 80)
    begin
      @(negedge clk);
      n++;
    end
    cmp_flag(tagged_abort === 1'b1, "abort reached");
    msr(1'b0, opsr_pkg::IDX_CONTROL, 64'h0);
    cmp_flag(rd[18] === 1'b0 && rd[58:40] === 19'h0 && irq_count == c0, "abort reload");
    rd2 = rd;
    msr(1'b0, opsr_pkg::IDX_CONTROL, 64'h0);
    cmp_flag(rd[58:32] !== rd2[58:32], "counting after abort");
    msr(1'b1, opsr_pkg::IDX_CONTROL, 64'h0);
  endtask

  initial
  begin
    reset = 1'b1;
    msr_req = '0;
    {free_dispatch, do_abort} = 2'h0;
    miss_delay = 8'h5;
    info = INFO_A;
    {mismatches, total_checks, irq_count} = 0;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    t_regs();
    t_clock_sample();
    t_dispatch_sample();
    t_abort();
    stop_test();
  end
endmodule
